/* File: csl_bank.v */
// Low special function register bank with port zero bus multiplexer.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "csl_defines.vh"
module csl_bank (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  input wire wb_sel_i,
  output reg [7:0] wb_dat_o,
  output wire wb_ack_o,
  // Core stack and pointer events
  input wire sp_push_i,
  input wire sp_pop_i,
  input wire [15:0] active_data_pointer_load_i,
  input wire active_data_pointer_we_i,
  output wire [15:0] active_data_pointer_o,
  output wire [7:0] stack_pointer_o,
  // Timer and interrupt events
  input wire timer0_ovf_i,
  input wire timer1_ovf_i,
  input wire timer0_vector_i,
  input wire timer1_vector_i,
  input wire ext_irq0_vector_i,
  input wire ext_irq1_vector_i,
  input wire ext_irq0_pin_i,
  input wire ext_irq1_pin_i,
  input wire auxiliary_interrupt_i,
  input wire wake_up_i,
  output wire timer0_run_o,
  output wire timer1_run_o,
  output wire ext_irq0_pending_o,
  output wire ext_irq1_pending_o,
  output wire timer0_overflow_flag_o,
  output wire timer1_overflow_flag_o,
  // Power state
  output wire uart0_rate_doubler_o,
  output reg stop_mode_o,
  output reg idle_mode_o,
  // External memory mux
  input wire ext_cycle_i,
  input wire addr_latch_i,
  input wire [7:0] ext_addr_low_i,
  input wire [7:0] ext_wdata_i,
  input wire ext_write_i,
  output wire [7:0] ext_rdata_o,
  // Port zero pins
  input wire [7:0] port_zero_in_i,
  output reg [7:0] port_zero_out_o,
  output reg [7:0] port_zero_oe_o
);
  reg [7:0] port_zero;
  reg [7:0] stack_pointer;
  reg [15:0] dptr0;
  reg [15:0] dptr1;
  reg dpsel;
  reg [7:0] pwr;
  reg [7:0] tmr;
  reg [7:0] drive_low;
  reg [7:0] drive_high;
  reg [7:0] flash_config_one;
  reg ack;
  reg irq0_d;
  reg irq1_d;
  wire wr;
  wire rd;
  wire irq0_edge;
  wire irq1_edge;

  // Register address match used by the write path; the read mux uses a case on the address.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // One wait state: ack is registered, rises the cycle after the request and drops next.
  assign wb_ack_o = ack;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~ack;
  assign rd = wb_cyc_i & wb_stb_i & ~ack;

  always @(posedge clk_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= wb_cyc_i & wb_stb_i & ~ack;
  end

  // Falling edge of an active-low pin is the interrupt edge.
  assign irq0_edge = irq0_d & ~ext_irq0_pin_i;
  assign irq1_edge = irq1_d & ~ext_irq1_pin_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_zero <= `CSL_RST_PORT0;
      stack_pointer <= `CSL_RST_SP;
      dptr0 <= {`CSL_RST_ZERO, `CSL_RST_ZERO};
      dptr1 <= {`CSL_RST_ZERO, `CSL_RST_ZERO};
      dpsel <= 1'b0;
      pwr <= `CSL_RST_PWR;
      tmr <= `CSL_RST_ZERO;
      drive_low <= `CSL_RST_ZERO;
      drive_high <= `CSL_RST_ZERO;
      flash_config_one <= `CSL_RST_ZERO;
      irq0_d <= 1'b1;
      irq1_d <= 1'b1;
      stop_mode_o <= 1'b0;
      idle_mode_o <= 1'b0;
    end
    else
    begin
      irq0_d <= ext_irq0_pin_i;
      irq1_d <= ext_irq1_pin_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_PORT0))
        port_zero <= wb_dat_i;
      // Push pre-increments so the write lands above; pop decrements after.
      if (wr && hit(wb_adr_i, `CSL_OFS_SP))
        stack_pointer <= wb_dat_i;
      else if (sp_push_i && !sp_pop_i)
        stack_pointer <= stack_pointer + 8'h01;
      else if (sp_pop_i && !sp_push_i)
        stack_pointer <= stack_pointer - 8'h01;
      if (wr && hit(wb_adr_i, `CSL_OFS_DATA_POINTER_ZERO_LOW))
        dptr0[7:0] <= wb_dat_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_DATA_POINTER_ZERO_HIGH))
        dptr0[15:8] <= wb_dat_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_DATA_POINTER_ONE_LOW))
        dptr1[7:0] <= wb_dat_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_DATA_POINTER_ONE_HIGH))
        dptr1[15:8] <= wb_dat_i;
      if (active_data_pointer_we_i && !dpsel)
        dptr0 <= active_data_pointer_load_i;
      if (active_data_pointer_we_i && dpsel)
        dptr1 <= active_data_pointer_load_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_DPSEL))
        dpsel <= wb_dat_i[0];
      if (wr && hit(wb_adr_i, `CSL_OFS_DRVL))
        drive_low <= wb_dat_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_DRVH))
        drive_high <= wb_dat_i;
      if (wr && hit(wb_adr_i, `CSL_OFS_FCFG))
        flash_config_one <= wb_dat_i;
      // Stop and idle are write strobes; stored bits stay zero.
      if (wr && hit(wb_adr_i, `CSL_OFS_PWR))
      begin
        pwr[`CSL_PWR_DBL] <= wb_dat_i[`CSL_PWR_DBL];
        pwr[`CSL_PWR_UF1] <= wb_dat_i[`CSL_PWR_UF1];
        pwr[`CSL_PWR_UF0] <= wb_dat_i[`CSL_PWR_UF0];
        if (wb_dat_i[`CSL_PWR_STOP])
          stop_mode_o <= 1'b1;
        if (wb_dat_i[`CSL_PWR_IDLE])
          idle_mode_o <= 1'b1;
      end
      else if (auxiliary_interrupt_i || wake_up_i)
        idle_mode_o <= 1'b0;
      // Hardware set wins over a software clear in the same cycle.
      if (wr && hit(wb_adr_i, `CSL_OFS_TMR))
      begin
        tmr[`CSL_TMR_TR1] <= wb_dat_i[`CSL_TMR_TR1];
        tmr[`CSL_TMR_TR0] <= wb_dat_i[`CSL_TMR_TR0];
        tmr[`CSL_TMR_IT1] <= wb_dat_i[`CSL_TMR_IT1];
        tmr[`CSL_TMR_IT0] <= wb_dat_i[`CSL_TMR_IT0];
      end
      if (timer1_ovf_i)
        tmr[`CSL_TMR_TF1] <= 1'b1;
      else if (timer1_vector_i)
        tmr[`CSL_TMR_TF1] <= 1'b0;
      else if (wr && hit(wb_adr_i, `CSL_OFS_TMR))
        tmr[`CSL_TMR_TF1] <= wb_dat_i[`CSL_TMR_TF1];
      if (timer0_ovf_i)
        tmr[`CSL_TMR_TF0] <= 1'b1;
      else if (timer0_vector_i)
        tmr[`CSL_TMR_TF0] <= 1'b0;
      else if (wr && hit(wb_adr_i, `CSL_OFS_TMR))
        tmr[`CSL_TMR_TF0] <= wb_dat_i[`CSL_TMR_TF0];
      if (irq1_edge)
        tmr[`CSL_TMR_IE1] <= 1'b1;
      else if (ext_irq1_vector_i)
        tmr[`CSL_TMR_IE1] <= 1'b0;
      else if (wr && hit(wb_adr_i, `CSL_OFS_TMR))
        tmr[`CSL_TMR_IE1] <= wb_dat_i[`CSL_TMR_IE1];
      if (irq0_edge)
        tmr[`CSL_TMR_IE0] <= 1'b1;
      else if (ext_irq0_vector_i)
        tmr[`CSL_TMR_IE0] <= 1'b0;
      else if (wr && hit(wb_adr_i, `CSL_OFS_TMR))
        tmr[`CSL_TMR_IE0] <= wb_dat_i[`CSL_TMR_IE0];
    end
  end

  // Level mode shows the inverted pin live instead of the latched flag.
  assign ext_irq1_pending_o = tmr[`CSL_TMR_IT1] ? tmr[`CSL_TMR_IE1] :
                              ~ext_irq1_pin_i;
  assign ext_irq0_pending_o = tmr[`CSL_TMR_IT0] ? tmr[`CSL_TMR_IE0] :
                              ~ext_irq0_pin_i;
  assign timer1_overflow_flag_o = tmr[`CSL_TMR_TF1];
  assign timer0_overflow_flag_o = tmr[`CSL_TMR_TF0];
  // Stop freezes timers as well as the core.
  assign timer1_run_o = tmr[`CSL_TMR_TR1] & ~stop_mode_o;
  assign timer0_run_o = tmr[`CSL_TMR_TR0] & ~stop_mode_o;
  assign uart0_rate_doubler_o = pwr[`CSL_PWR_DBL];
  assign active_data_pointer_o = dpsel ? dptr1 : dptr0;
  assign stack_pointer_o = stack_pointer;
  assign ext_rdata_o = port_zero_in_i;

  // Read data is registered with ack, so it is valid while ack is high.
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 8'h00;
    else if (rd)
    begin
      case (wb_adr_i)
        `CSL_OFS_PORT0: wb_dat_o <= port_zero_in_i;
        `CSL_OFS_SP: wb_dat_o <= stack_pointer;
        `CSL_OFS_DATA_POINTER_ZERO_LOW: wb_dat_o <= dptr0[7:0];
        `CSL_OFS_DATA_POINTER_ZERO_HIGH: wb_dat_o <= dptr0[15:8];
        `CSL_OFS_DATA_POINTER_ONE_LOW: wb_dat_o <= dptr1[7:0];
        `CSL_OFS_DATA_POINTER_ONE_HIGH: wb_dat_o <= dptr1[15:8];
        `CSL_OFS_DPSEL: wb_dat_o <= {7'h00, dpsel};
        `CSL_OFS_PWR: wb_dat_o <= `CSL_PWR_FIXED |
          {pwr[7], 3'h0, pwr[3:2], 2'h0};
        `CSL_OFS_TMR: wb_dat_o <= {tmr[7:4], ext_irq1_pending_o,
          tmr[2], ext_irq0_pending_o, tmr[0]};
        `CSL_OFS_DRVL: wb_dat_o <= drive_low;
        `CSL_OFS_DRVH: wb_dat_o <= drive_high;
        `CSL_OFS_FCFG: wb_dat_o <= flash_config_one;
        default: wb_dat_o <= 8'h00;
      endcase
    end
  end

  // Pin mux. In GPIO use a pin drives when either drive-select bit is set.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_zero_out_o <= 8'h00;
      port_zero_oe_o <= 8'h00;
    end
    else if (flash_config_one[`CSL_FCFG_EXTBUS])
    begin
      if (ext_cycle_i && addr_latch_i)
      begin
        port_zero_out_o <= ext_addr_low_i;
        port_zero_oe_o <= 8'hff;
      end
      else if (ext_cycle_i && ext_write_i)
      begin
        port_zero_out_o <= ext_wdata_i;
        port_zero_oe_o <= 8'hff;
      end
      else
      begin
        port_zero_out_o <= 8'h00;
        port_zero_oe_o <= 8'h00;
      end
    end
    else
    begin
      port_zero_out_o <= port_zero;
      port_zero_oe_o <= drive_low | drive_high;
    end
  end
endmodule // csl_bank

/* File: csl_defines.vh */
// Offsets, field positions, reset values and timing for the low register bank.
`ifndef CSL_DEFINES_VH
`define CSL_DEFINES_VH
`define CSL_OFS_PORT0 8'h80
`define CSL_OFS_SP 8'h81
`define CSL_OFS_DATA_POINTER_ZERO_LOW 8'h82
`define CSL_OFS_DATA_POINTER_ZERO_HIGH 8'h83
`define CSL_OFS_DATA_POINTER_ONE_LOW 8'h84
`define CSL_OFS_DATA_POINTER_ONE_HIGH 8'h85
`define CSL_OFS_DPSEL 8'h86
`define CSL_OFS_PWR 8'h87
`define CSL_OFS_TMR 8'h88
`define CSL_OFS_DRVL 8'hac
`define CSL_OFS_DRVH 8'had
`define CSL_OFS_FCFG 8'h93
`define CSL_RST_PORT0 8'hff
`define CSL_RST_SP 8'h07
`define CSL_RST_ZERO 8'h00
`define CSL_RST_PWR 8'h30
`define CSL_PWR_FIXED 8'h30
`define CSL_PWR_DBL 7
`define CSL_PWR_UF1 3
`define CSL_PWR_UF0 2
`define CSL_PWR_STOP 1
`define CSL_PWR_IDLE 0
`define CSL_TMR_TF1 7
`define CSL_TMR_TR1 6
`define CSL_TMR_TF0 5
`define CSL_TMR_TR0 4
`define CSL_TMR_IE1 3
`define CSL_TMR_IT1 2
`define CSL_TMR_IE0 1
`define CSL_TMR_IT0 0
`define CSL_FCFG_EXTBUS 1
`define CSL_ALE_HOLD 2'd1
`endif

/* File: csl_bank_asserts.sv */
// Port-level assertions for the low register bank.
`timescale 1ns/100ps
module csl_bank_asserts (
  // Clock, reset and bus
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_ack_o,
  input wire [7:0] wb_adr_i,
  // Stack events
  input wire sp_push_i, sp_pop_i,
  input wire [7:0] stack_pointer_o,
  // Power and timers
  input wire stop_mode_o, idle_mode_o, auxiliary_interrupt_i,
  input wire timer0_run_o, timer1_run_o, timer0_ovf_i, timer1_ovf_i,
  input wire timer1_vector_i, timer0_overflow_flag_o, timer1_overflow_flag_o
);
  // A bus write to SP or PWR beats a core event in the same cycle, so it is excluded.
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i;
  wire spw = req & (wb_adr_i == 8'h81);
  wire pw = req & (wb_adr_i == 8'h87);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $past(rst_i) |-> stack_pointer_o == 8'h07; endproperty
  a_rst: assert property (p_rst) else $error("sp reset value");
  property p_push;
    sp_push_i && !sp_pop_i && !spw && !stop_mode_o
      |=> stack_pointer_o - $past(stack_pointer_o) == 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("sp push");
  property p_pop;
    sp_pop_i && !sp_push_i && !spw && !stop_mode_o
      |=> $past(stack_pointer_o) - stack_pointer_o == 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("sp pop");
  property p_stop; stop_mode_o |=> stop_mode_o; endproperty
  a_stop: assert property (p_stop) else $error("stop left");
  property p_halt; stop_mode_o |-> !timer0_run_o && !timer1_run_o; endproperty
  a_halt: assert property (p_halt) else $error("timer runs in stop");
  property p_idle;
    idle_mode_o && auxiliary_interrupt_i && !pw |=> !idle_mode_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle kept");
  property p_tf0; timer0_ovf_i |=> timer0_overflow_flag_o; endproperty
  a_tf0: assert property (p_tf0) else $error("overflow not set");
  property p_tf1;
    timer1_vector_i && !timer1_ovf_i |=> !timer1_overflow_flag_o;
  endproperty
  a_tf1: assert property (p_tf1) else $error("overflow kept");
  c_push: cover property (sp_push_i);
  c_stop: cover property ($rose(stop_mode_o));
  c_idle: cover property ($fell(idle_mode_o));
endmodule // csl_bank_asserts

bind csl_bank csl_bank_asserts u_chk (.*);

/* File: csl_bank_tb.sv */
// Self-checking bench for the low register bank.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module csl_bank_tb;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sel = 1;
  reg push = 0, pop = 0, dwe = 0, ovf0 = 0, ovf1 = 0, vec1 = 0, ivec0 = 0;
  reg vec0 = 0, ivec1 = 0;
  reg pin0 = 1, pin1 = 1, aux = 0, wake = 0, ecyc = 0, ale = 0, ewr = 0;
  reg [7:0] adr = 0, wdat = 0, pins = 0, a8 = 0, wd = 0, rdat;
  reg [7:0] dp [0:3];
  reg [15:0] dld = 0;
  integer n_errors = 0, checks_done = 0, cycles = 0, i;
  integer seed = 32'ha95b8acb;
  wire [7:0] rd, sp, pout, poe, erd;
  wire [15:0] adp;
  wire ack, r0, r1, ip0, ip1, tf0, tf1, dbl, stp, idl;
  csl_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .sp_push_i(push),
    .sp_pop_i(pop), .active_data_pointer_load_i(dld), .active_data_pointer_we_i(dwe),
    .active_data_pointer_o(adp), .stack_pointer_o(sp),
    .timer0_ovf_i(ovf0), .timer1_ovf_i(ovf1), .timer0_vector_i(vec0),
    .timer1_vector_i(vec1), .ext_irq0_vector_i(ivec0),
    .ext_irq1_vector_i(ivec1), .ext_irq0_pin_i(pin0), .ext_irq1_pin_i(pin1),
    .auxiliary_interrupt_i(aux), .wake_up_i(wake), .timer0_run_o(r0),
    .timer1_run_o(r1), .ext_irq0_pending_o(ip0), .ext_irq1_pending_o(ip1),
    .timer0_overflow_flag_o(tf0), .timer1_overflow_flag_o(tf1),
    .uart0_rate_doubler_o(dbl), .stop_mode_o(stp), .idle_mode_o(idl),
    .ext_cycle_i(ecyc), .addr_latch_i(ale), .ext_addr_low_i(a8),
    .ext_wdata_i(wd), .ext_write_i(ewr), .ext_rdata_o(erd),
    .port_zero_in_i(pins), .port_zero_out_o(pout), .port_zero_oe_o(poe));
  always #20 clk_i = ~clk_i;
  // A hung handshake is caught here rather than by a wait in each task.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      final_report;
    end
  end
  task final_report;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    begin
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      tk(1);
      while (ack !== 1'b1) tk(1);
      rdat = rd;
      cyc <= 0; stb <= 0; we <= 0;
      tk(1);
    end
  endtask
  task chk_rd(input [7:0] a, input [7:0] e);
    begin
      bus(0, a, 8'h00);
      `CHK("read", e, rdat)
    end
  endtask
  function [7:0] rst_val(input [7:0] a);
    case (a)
      8'h80: rst_val = pins;
      8'h81: rst_val = 8'h07;
      8'h87: rst_val = 8'h30;
      default: rst_val = 8'h00;
    endcase
  endfunction
  initial
  begin
    tk(20);
    rst_i <= 0;
    pins <= $random(seed);
    tk(1);
    for (i = 8'h80; i < 8'h8a; i++) chk_rd(i, rst_val(i));
    bus(1, 8'hac, 8'hff);
    tk(1);
    `CHK("latch", 8'hff, pout)
    wd = $random(seed);
    bus(1, 8'h80, wd);
    bus(1, 8'hac, 8'h0f);
    bus(1, 8'had, 8'h30);
    tk(1);
    `CHK("gpio out", wd, pout)
    `CHK("gpio oe", 8'h3f, poe)
    bus(1, 8'h93, 8'h02);
    a8 <= $random(seed);
    wd <= $random(seed);
    ecyc <= 1;
    ale <= 1;
    tk(2);
    `CHK("bus addr", a8, pout)
    `CHK("bus oe", 8'hff, poe)
    ale <= 0;
    ewr <= 1;
    tk(2);
    `CHK("bus data", wd, pout)
    `CHK("bus read", pins, erd)
    ecyc <= 0;
    ewr <= 0;
    for (i = 0; i < 4; i++)
    begin
      dp[i] = $random(seed);
      bus(1, 8'h82 + i, dp[i]);
    end
    for (i = 0; i < 2; i++)
    begin
      wd = $random(seed);
      wd[0] = i;
      bus(1, 8'h86, wd);
      chk_rd(8'h86, {7'h00, wd[0]});
      `CHK("pointer", wd[0] ? {dp[3], dp[2]} : {dp[1], dp[0]}, adp)
      dld <= $random(seed);
      dwe <= 1;
      tk(1);
      dwe <= 0;
      tk(1);
      `CHK("load", dld, adp)
      chk_rd(8'h83 + 2 * i, dld[15:8]);
      wd = $random(seed) & 8'hfc;
      wd[7] = i;
      bus(1, 8'h87, wd);
      chk_rd(8'h87, (wd & 8'h8c) | 8'h30);
      `CHK("doubler", wd[7], dbl)
    end
    wd = $random(seed);
    bus(1, 8'h81, wd);
    push <= 1;
    tk(1);
    push <= 0;
    tk(1);
    `CHK("push", wd + 8'h01, sp)
    pop <= 1;
    tk(1);
    pop <= 0;
    tk(1);
    `CHK("pop", wd, sp)
    bus(1, 8'h88, 8'h50);
    `CHK("run", 2'b11, {r1, r0})
    bus(1, 8'h88, 8'h00);
    `CHK("halt", 2'b00, {r1, r0})
    ovf0 <= 1;
    ovf1 <= 1;
    tk(1);
    ovf0 <= 0;
    ovf1 <= 0;
    vec1 <= 1;
    tk(1);
    vec1 <= 0;
    tk(1);
    `CHK("overflow", 2'b01, {tf1, tf0})
    chk_rd(8'h88, 8'h20);
    bus(1, 8'h88, 8'h00);
    `CHK("sw clear", 1'b0, tf0)
    ovf0 <= 1;
    tk(1);
    ovf0 <= 0;
    vec0 <= 1;
    tk(1);
    `CHK("set 0", 1'b1, tf0)
    vec0 <= 0;
    tk(1);
    `CHK("vector 0", 1'b0, tf0)
    pin0 <= 0;
    tk(3);
    `CHK("level low", 1'b1, ip0)
    pin0 <= 1;
    tk(3);
    `CHK("level high", 1'b0, ip0)
    bus(1, 8'h88, 8'h05);
    pin0 <= 0;
    pin1 <= 0;
    tk(3);
    pin0 <= 1;
    pin1 <= 1;
    tk(3);
    `CHK("edge", 2'b11, {ip1, ip0})
    ivec0 <= 1;
    tk(1);
    ivec0 <= 0;
    tk(1);
    `CHK("serviced", 2'b10, {ip1, ip0})
    ivec1 <= 1;
    tk(1);
    ivec1 <= 0;
    tk(1);
    `CHK("serviced 1", 2'b00, {ip1, ip0})
    for (i = 0; i < 2; i++)
    begin
      bus(1, 8'h87, 8'h01);
      `CHK("idle", 1'b1, idl)
      chk_rd(8'h87, 8'h30);
      aux <= i;
      wake <= !i;
      tk(1);
      aux <= 0;
      wake <= 0;
      tk(1);
      `CHK("wake", 1'b0, idl)
    end
    bus(1, 8'h88, 8'h50);
    bus(1, 8'h87, 8'h02);
    aux <= 1;
    tk(1);
    aux <= 0;
    tk(2);
    `CHK("stop", 3'b100, {stp, r1, r0})
    rst_i <= 1;
    tk(2);
    rst_i <= 0;
    tk(1);
    `CHK("after reset", {1'b0, 8'h07}, {stp, sp})
    final_report;
  end
endmodule // csl_bank_tb
